/* File: sfpi_map.vh */
// Constants for the serial flash pin interface
`ifndef SFPI_MAP_VH
`define SFPI_MAP_VH
`define SFPI_CMD_WIDTH 8
`define SFPI_ADDR_WIDTH 24
`define SFPI_BUF_DEPTH 256
`define SFPI_BUF_AW 8
`define SFPI_ARRAY_MBIT 32
`define SFPI_MODE_SINGLE 2'h0
`define SFPI_MODE_DUAL 2'h1
`define SFPI_MODE_QUAD 2'h2
`define SFPI_CMD_READ 8'h03
`define SFPI_CMD_DUAL_READ 8'h3b
`define SFPI_CMD_QUAD_READ 8'h6b
`define SFPI_CMD_PROGRAM 8'h02
`define SFPI_CMD_WRSR1 8'h01
`define SFPI_CMD_WRSR2 8'h31
`define SFPI_CMD_WRSR3 8'h11
`define SFPI_CMD_RDSR1 8'h05
`define SFPI_SR1_RESET 8'h00
`define SFPI_SR2_RESET 8'h00
`define SFPI_SR3_RESET 8'h00
`define SFPI_SR2_QE_BIT 1
`define SFPI_SR2_CMP_BIT 6
`define SFPI_SR1_TB_BIT 5
`define SFPI_SR1_PROTECT_SIZE_BIT_BIT 6
`define SFPI_SR3_HOLDRST_BIT 7
`define SFPI_BUSY_CYCLES 16'h0100
`endif

/* File: sfpi_edge_sync.v */
// Two-stage synchroniser with edge detection for pin inputs
`timescale 1ns/1ps
module sfpi_edge_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input wire mclk,
    input wire rstn,
    input wire [WIDTH-1:0] pinIn,
    output wire [WIDTH-1:0] level,
    output wire [WIDTH-1:0] rise,
    output wire [WIDTH-1:0] fall
);
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;
    reg [WIDTH-1:0] prev_reg;
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= INIT;
            sync_reg <= INIT;
            prev_reg <= INIT;
        end else begin
            meta_reg <= pinIn;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end
    assign level = sync_reg;
    assign rise = sync_reg & ~prev_reg;
    assign fall = ~sync_reg & prev_reg;
endmodule

/* File: sfpi_pin_interface.v */
// Pin-level serial interface control of a serial flash device
// How it works
// - Chip select falling edge starts a new command.
// - Chip select rising edge ends the command sequence.
// - With chip select high the device is deselected and in standby.
// - A running program cycle finishes before standby.
// - Input bits are ignored while deselected.
// - Serial output floats when deselected or in reset.
// - Command, address and write data sampled on clock rising edges.
// - Output data changes on clock falling edges.
// - Multi-I/O reads turn data line 0 into an output.
// - Serial output stays data line 1 output during multi-I/O reads.
// - Asserted write protect rejects status register writes.
// - Write protect and protection bits decide hardware protected regions.
// - Quad enable makes write protect pin data line 2.
// - Program data staged in a 256-byte buffer before the array.
// - Pause starts only when selected with clock low; it freezes the link.
// - Without quad enable, data line 3 is pause or reset per bit 7.
`timescale 1ns/1ps
`include "sfpi_map.vh"
module sfpi_pin_interface #(
    parameter BUSY_CYCLES = `SFPI_BUSY_CYCLES,
    parameter BUF_DEPTH = `SFPI_BUF_DEPTH
) (
    input wire mclk,
    input wire rstn,
    input wire csN,
    input wire sck,
    input wire dataLine0In,
    output reg dataLine0Out,
    output reg dataLine0OeN,
    input wire dataLine1In,
    output reg dataLine1Out,
    output reg dataLine1OeN,
    input wire dataLine2In,
    output reg dataLine2Out,
    output reg dataLine2OeN,
    input wire dataLine3In,
    output reg dataLine3Out,
    output reg dataLine3OeN,
    input wire [7:0] arrayRdData,
    output reg [23:0] arrayAddr,
    output reg [7:0] arrayWrData,
    output reg arrayWrStrobe,
    output reg busy,
    output reg standby,
    output reg [7:0] statusReg1,
    output reg [7:0] statusReg2,
    output reg [7:0] statusReg3
);
    localparam ST_IDLE = 3'h0;
    localparam ST_CMD = 3'h1;
    localparam ST_ADDR = 3'h2;
    localparam ST_RDATA = 3'h3;
    localparam ST_WDATA = 3'h4;
    localparam ST_SRDATA = 3'h5;
    localparam ST_RSR = 3'h6;

    wire [5:0] lvl;
    wire [5:0] rise;
    wire [5:0] fall;
    sfpi_edge_sync #(.WIDTH(6), .INIT(6'h3d)) uSync (
        .mclk(mclk),
        .rstn(rstn),
        .pinIn({dataLine3In, dataLine2In, dataLine1In, dataLine0In, sck, csN}),
        .level(lvl),
        .rise(rise),
        .fall(fall)
    );
    wire csLvl = lvl[0];
    wire sckRise = rise[1];
    wire sckFall = fall[1];
    wire [3:0] dIn = lvl[5:2];

    reg [2:0] state_reg;
    reg [7:0] cmd_reg;
    reg [23:0] addr_reg;
    reg [7:0] shift_reg;
    reg [4:0] bitCnt_reg;
    reg [1:0] mode_reg;
    reg outEn_reg;
    reg paused_reg;
    reg srLock_reg;
    reg [15:0] busyCnt_reg;
    reg [`SFPI_BUF_AW:0] bufCnt_reg;
    reg [`SFPI_BUF_AW-1:0] flushIdx_reg;
    reg flushing_reg;
    reg [7:0] pageBuf [0:BUF_DEPTH-1];
    reg [2:0] srSel_reg;

    wire qe = statusReg2[`SFPI_SR2_QE_BIT];
    wire holdSel = ~statusReg3[`SFPI_SR3_HOLDRST_BIT];
    wire wpAsserted = ~qe & ~dIn[2];
    wire pinHold = ~qe & holdSel & ~dIn[3];
    wire pinReset = ~qe & ~holdSel & ~dIn[3];

    // Width of a data group per mode
    function [2:0] modeBits;
        input [1:0] m;
        begin
            case (m)
                `SFPI_MODE_DUAL: modeBits = 3'h2;
                `SFPI_MODE_QUAD: modeBits = 3'h4;
                default: modeBits = 3'h1;
            endcase
        end
    endfunction

    // Region protected by the protect bits and write protect
    function isProtected;
        input [23:0] a;
        input [7:0] s1;
        input cmp;
        input wp;
        reg [2:0] bp;
        reg [3:0] sh;
        reg hit;
        begin
            bp = s1[4:2];
            sh = s1[`SFPI_SR1_PROTECT_SIZE_BIT_BIT] ? 4'h3 : 4'h6;
            if (bp == 3'h0)
                hit = 1'b0;
            else if (s1[`SFPI_SR1_TB_BIT])
                hit = (a[23:21] >> sh[1:0]) < {2'h0, bp[0]} + (bp >> 1);
            else
                hit = (~a[23:21] >> sh[1:0]) < {2'h0, bp[0]} + (bp >> 1);
            isProtected = (hit ^ cmp) & wp;
        end
    endfunction

    wire selStart = fall[0];
    wire selEnd = rise[0];
    wire hiddenSel = csLvl | pinReset;
    wire holdStart = ~paused_reg & pinHold & ~csLvl & ~lvl[1];
    wire linkActive = ~hiddenSel & ~paused_reg & ~holdStart;
    wire flushStart = selEnd & (state_reg == ST_WDATA) & (|bufCnt_reg);
    wire [`SFPI_BUF_AW-1:0] flushPtr = addr_reg[`SFPI_BUF_AW-1:0] + flushIdx_reg;
    wire [`SFPI_BUF_AW-1:0] fillPtr = addr_reg[`SFPI_BUF_AW-1:0] + bufCnt_reg[`SFPI_BUF_AW-1:0];

    // only edges matter, so idle low or high samples the same
    wire takeRise = linkActive & sckRise & (state_reg != ST_IDLE);
    wire takeFall = linkActive & sckFall;
    wire [2:0] nb = modeBits(mode_reg);
    wire [7:0] inShift = (nb == 3'h4) ? {shift_reg[3:0], dIn} :
        (nb == 3'h2) ? {shift_reg[5:0], dIn[1:0]} : {shift_reg[6:0], dIn[0]};
    wire [4:0] inCnt = bitCnt_reg + {2'h0, nb};
    wire [7:0] cmdShift = {cmd_reg[6:0], dIn[0]};
    wire srWrite = (cmdShift == `SFPI_CMD_WRSR1) | (cmdShift == `SFPI_CMD_WRSR2) |
        (cmdShift == `SFPI_CMD_WRSR3);

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_IDLE;
            cmd_reg <= 8'h00;
            addr_reg <= 24'h000000;
            shift_reg <= 8'h00;
            bitCnt_reg <= 5'h00;
            mode_reg <= `SFPI_MODE_SINGLE;
            outEn_reg <= 1'b0;
            paused_reg <= 1'b0;
            srLock_reg <= 1'b0;
            busyCnt_reg <= 16'h0000;
            bufCnt_reg <= {(`SFPI_BUF_AW+1){1'b0}};
            flushIdx_reg <= {`SFPI_BUF_AW{1'b0}};
            flushing_reg <= 1'b0;
            srSel_reg <= 3'h0;
            statusReg1 <= `SFPI_SR1_RESET;
            statusReg2 <= `SFPI_SR2_RESET;
            statusReg3 <= `SFPI_SR3_RESET;
            arrayAddr <= 24'h000000;
            arrayWrData <= 8'h00;
            arrayWrStrobe <= 1'b0;
            busy <= 1'b0;
            standby <= 1'b1;
        end else begin
            arrayWrStrobe <= 1'b0;
            if (holdStart)
                paused_reg <= 1'b1;
            else if (paused_reg && !pinHold)
                paused_reg <= 1'b0;
            // Internal program cycle runs on regardless of select
            if (flushing_reg) begin
                arrayAddr <= {addr_reg[23:8], flushPtr};
                arrayWrData <= pageBuf[flushPtr];
                arrayWrStrobe <= ~isProtected(addr_reg, statusReg1,
                    statusReg2[`SFPI_SR2_CMP_BIT], ~dIn[2] | qe);
                flushIdx_reg <= flushIdx_reg + 1'b1;
                if ({1'b0, flushIdx_reg} == bufCnt_reg - 1'b1)
                    flushing_reg <= 1'b0;
            end else if (busyCnt_reg != 16'h0000) begin
                busyCnt_reg <= busyCnt_reg - 1'b1;
            end
            busy <= flushStart | flushing_reg | (busyCnt_reg != 16'h0000);
            standby <= hiddenSel & ~flushStart & ~flushing_reg &
                (busyCnt_reg == 16'h0000);
            if (hiddenSel) begin
                outEn_reg <= 1'b0;
                if (flushStart) begin
                    flushing_reg <= 1'b1;
                    flushIdx_reg <= {`SFPI_BUF_AW{1'b0}};
                    busyCnt_reg <= BUSY_CYCLES[15:0];
                end
                state_reg <= ST_IDLE;
                mode_reg <= `SFPI_MODE_SINGLE;
            end else if (selStart) begin
                state_reg <= ST_CMD;
                bitCnt_reg <= 5'h00;
                cmd_reg <= 8'h00;
                outEn_reg <= 1'b0;
            end else if (takeRise) begin
                case (state_reg)
                    ST_CMD: begin
                        cmd_reg <= cmdShift;
                        bitCnt_reg <= bitCnt_reg + 5'h01;
                        if (bitCnt_reg == 5'h07) begin
                            bitCnt_reg <= 5'h00;
                            srSel_reg <= {cmdShift == `SFPI_CMD_WRSR3,
                                cmdShift == `SFPI_CMD_WRSR2, cmdShift == `SFPI_CMD_WRSR1};
                            if (cmdShift == `SFPI_CMD_RDSR1)
                                state_reg <= ST_RSR;
                            else if (srWrite && (wpAsserted || busy))
                                state_reg <= ST_IDLE;
                            else if (srWrite)
                                state_reg <= ST_SRDATA;
                            else if (cmdShift == `SFPI_CMD_READ || cmdShift ==
                                `SFPI_CMD_DUAL_READ || cmdShift == `SFPI_CMD_QUAD_READ ||
                                (cmdShift == `SFPI_CMD_PROGRAM && !busy))
                                state_reg <= ST_ADDR;
                            else
                                state_reg <= ST_IDLE;
                        end
                    end
                    ST_ADDR: begin
                        addr_reg <= {addr_reg[22:0], dIn[0]};
                        bitCnt_reg <= bitCnt_reg + 5'h01;
                        if (bitCnt_reg == 5'h17) begin
                            bitCnt_reg <= 5'h00;
                            arrayAddr <= {addr_reg[22:0], dIn[0]};
                            bufCnt_reg <= {(`SFPI_BUF_AW+1){1'b0}};
                            if (cmd_reg == `SFPI_CMD_PROGRAM) begin
                                state_reg <= ST_WDATA;
                            end else begin
                                state_reg <= ST_RDATA;
                                if (cmd_reg == `SFPI_CMD_DUAL_READ)
                                    mode_reg <= `SFPI_MODE_DUAL;
                                else if (cmd_reg == `SFPI_CMD_QUAD_READ && qe)
                                    mode_reg <= `SFPI_MODE_QUAD;
                            end
                        end
                    end
                    ST_WDATA: begin
                        shift_reg <= inShift;
                        bitCnt_reg <= inCnt;
                        if (inCnt == 5'h08) begin
                            bitCnt_reg <= 5'h00;
                            pageBuf[fillPtr] <= inShift;
                            if (!bufCnt_reg[`SFPI_BUF_AW])
                                bufCnt_reg <= bufCnt_reg + 1'b1;
                        end
                    end
                    ST_SRDATA: begin
                        shift_reg <= inShift;
                        bitCnt_reg <= inCnt;
                        if (inCnt == 5'h08) begin
                            if (srSel_reg[0])
                                statusReg1 <= inShift;
                            if (srSel_reg[1])
                                statusReg2 <= inShift;
                            if (srSel_reg[2])
                                statusReg3 <= inShift;
                            state_reg <= ST_IDLE;
                        end
                    end
                    default: begin
                        bitCnt_reg <= bitCnt_reg;
                    end
                endcase
            end else if (takeFall && (state_reg == ST_RDATA || state_reg == ST_RSR)) begin
                if (!outEn_reg || bitCnt_reg == 5'h00) begin
                    shift_reg <= (state_reg == ST_RSR) ? statusReg1 : arrayRdData;
                    bitCnt_reg <= {2'h0, nb};
                    if (outEn_reg || state_reg == ST_RSR)
                        arrayAddr <= arrayAddr + 24'h000001;
                end else begin
                    shift_reg <= (nb == 3'h4) ? {shift_reg[3:0], 4'h0} :
                        (nb == 3'h2) ? {shift_reg[5:0], 2'h0} : {shift_reg[6:0], 1'b0};
                    bitCnt_reg <= (inCnt == 5'h08) ? 5'h00 : inCnt;
                end
                outEn_reg <= 1'b1;
            end
        end
    end

    // Pin drivers, registered; enables are active low
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dataLine0Out <= 1'b0;
            dataLine1Out <= 1'b0;
            dataLine2Out <= 1'b0;
            dataLine3Out <= 1'b0;
            dataLine0OeN <= 1'b1;
            dataLine1OeN <= 1'b1;
            dataLine2OeN <= 1'b1;
            dataLine3OeN <= 1'b1;
        end else begin
            dataLine0Out <= (mode_reg == `SFPI_MODE_QUAD) ? shift_reg[4] : shift_reg[6];
            dataLine1Out <= (mode_reg == `SFPI_MODE_QUAD) ? shift_reg[5] : shift_reg[7];
            dataLine2Out <= shift_reg[6];
            dataLine3Out <= shift_reg[7];
            dataLine1OeN <= ~(outEn_reg & linkActive);
            dataLine0OeN <= ~(outEn_reg & linkActive & mode_reg != `SFPI_MODE_SINGLE);
            dataLine2OeN <= ~(outEn_reg & linkActive & mode_reg == `SFPI_MODE_QUAD);
            dataLine3OeN <= ~(outEn_reg & linkActive & mode_reg == `SFPI_MODE_QUAD);
        end
    end
endmodule

/* File: sfpi_pin_interface_props.sv */
// Port checker for the serial flash pin interface
`timescale 1ns/1ps
module sfpi_pin_props (
    input wire mclk,
    input wire rstn,
    input wire csN,
    input wire sck,
    input wire dataLine2In,
    input wire dataLine3In,
    input wire dataLine0OeN,
    input wire dataLine1OeN,
    input wire dataLine2OeN,
    input wire dataLine3OeN,
    input wire arrayWrStrobe,
    input wire busy,
    input wire standby,
    input wire [7:0] statusReg1,
    input wire [7:0] statusReg2,
    input wire [7:0] statusReg3
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    wire allFloat = dataLine0OeN & dataLine1OeN & dataLine2OeN & dataLine3OeN;
    wire qe = statusReg2[1];
    sequence s_desel; csN [*8]; endsequence
    sequence s_wpHeld; (!dataLine2In && !qe) [*4]; endsequence
    sequence s_paused; (!csN && !sck && !dataLine3In && !qe && !statusReg3[7]) [*6]; endsequence
    property p_floatOff; $rose(csN) |-> ##4 allFloat; endproperty
    a_floatOff: assert property (p_floatOff) else $error("Lines driven after deselect");
    property p_wake; $fell(csN) |-> ##[1:5] !standby; endproperty
    a_wake: assert property (p_wake) else $error("Standby kept while selected");
    property p_idle; (csN && !busy) [*8] |-> standby; endproperty
    a_idle: assert property (p_idle) else $error("No standby when deselected");
    property p_busyHold; busy |-> !standby; endproperty
    a_busyHold: assert property (p_busyHold) else $error("Standby during busy");
    property p_ignore; s_desel |=> $stable({statusReg1[7:2], statusReg2, statusReg3}); endproperty
    a_ignore: assert property (p_ignore) else $error("Status changed while deselected");
    property p_wp; s_wpHeld |=> $stable(statusReg1[7:2]); endproperty
    a_wp: assert property (p_wp) else $error("Status written under protect");
    property p_group; !dataLine0OeN |-> !dataLine1OeN; endproperty
    a_group: assert property (p_group) else $error("Line 0 driven alone");
    property p_quad; (!dataLine2OeN || !dataLine3OeN) |-> qe && !dataLine0OeN; endproperty
    a_quad: assert property (p_quad) else $error("Lines 2 or 3 driven off quad");
    property p_strobe; arrayWrStrobe |-> csN && !standby; endproperty
    a_strobe: assert property (p_strobe) else $error("Array write while selected");
    property p_pause; s_paused |-> allFloat; endproperty
    a_pause: assert property (p_pause) else $error("Lines driven in pause");
endmodule
bind sfpi_pin_interface sfpi_pin_props u_props (.mclk, .rstn, .csN, .sck, .dataLine2In,
    .dataLine3In, .dataLine0OeN, .dataLine1OeN, .dataLine2OeN, .dataLine3OeN, .arrayWrStrobe,
    .busy, .standby, .statusReg1, .statusReg2, .statusReg3);

/* File: sfpi_host_model.sv */
// Host controller model driving the serial flash pins
`timescale 1ns/1ps
module sfpi_host_model (
    output reg csN = 1'b1,
    output reg sck = 1'b0,
    output reg drv0 = 1'b1,
    output reg val0 = 1'b0,
    output reg drv23 = 1'b1,
    output reg wpN = 1'b1,
    output reg holdN = 1'b1,
    input wire line0,
    input wire line1,
    input wire line2,
    input wire line3
);
    reg cpol = 1'b0;
    task open_frame(input sel);
        begin
            sck = cpol;
            #80 csN = ~sel;
            #80;
        end
    endtask
    // Sampled late in the high phase: the answer lags the fall by several mclk
    task shift(input [7:0] tx, input integer w, output [7:0] rx);
        integer i;
        begin
            rx = 8'h00;
            drv0 = (w == 1);
            drv23 = (w != 4);
            for (i = 0; i < 8; i = i + w) begin
                sck = 1'b0;
                val0 = tx[7 - i];
                #80 sck = 1'b1;
                #80;
                if (w == 1) rx = {rx[6:0], line1};
                else if (w == 2) rx = {rx[5:0], line1, line0};
                else rx = {rx[3:0], line3, line2, line1, line0};
            end
        end
    endtask
    task paused_byte(input [7:0] tx);
        reg [7:0] rx;
        begin
            sck = 1'b0;
            #80 holdN = 1'b0;
            #80 shift(tx, 1, rx);
            sck = 1'b0;
            #80 holdN = 1'b1;
            #80;
        end
    endtask
    task close_frame;
        begin
            #80 sck = cpol;
            #80 csN = 1'b1;
            #160 drv0 = 1'b1;
            drv23 = 1'b1;
        end
    endtask
endmodule

/* File: sfpi_pin_interface_tb_top.sv */
// Self-checking bench for the serial flash pin interface
`timescale 1ns/1ps
module sfpi_pin_interface_tb_top;
    reg mclk = 1'b0;
    reg rstn = 1'b0;
    reg junk = 1'b0;
    integer mismatches = 0;
    integer testsRun = 0;
    integer wrCount = 0;
    reg [7:0] wrSeen [0:7];
    reg [7:0] adSeen [0:7];
    wire csN, sck, drv0, val0, drv23, wpN, holdN, o0, o1, o2, o3, e0, e1, e2, e3;
    wire strobe, busy, standby, line0, line1, line2, line3;
    wire [7:0] sr1, sr2, sr3, wrData;
    wire [23:0] addr;
    wire [7:0] rdData = addr[7:0] ^ 8'h5a;
    assign line0 = !e0 ? o0 : drv0 ? val0 : junk;
    assign line1 = !e1 ? o1 : junk;
    assign line2 = !e2 ? o2 : drv23 ? wpN : 1'b1;
    assign line3 = !e3 ? o3 : drv23 ? holdN : 1'b1;
    sfpi_pin_interface #(.BUSY_CYCLES(16)) uut (.mclk(mclk), .rstn(rstn), .csN(csN), .sck(sck),
        .dataLine0In(line0), .dataLine0Out(o0), .dataLine0OeN(e0), .dataLine1In(line1),
        .dataLine1Out(o1), .dataLine1OeN(e1), .dataLine2In(line2), .dataLine2Out(o2),
        .dataLine2OeN(e2), .dataLine3In(line3), .dataLine3Out(o3), .dataLine3OeN(e3),
        .arrayRdData(rdData), .arrayAddr(addr), .arrayWrData(wrData),
        .arrayWrStrobe(strobe), .busy(busy), .standby(standby), .statusReg1(sr1),
        .statusReg2(sr2), .statusReg3(sr3));
    sfpi_host_model host (.csN(csN), .sck(sck), .drv0(drv0), .val0(val0), .drv23(drv23),
        .wpN(wpN), .holdN(holdN), .line0(line0), .line1(line1), .line2(line2), .line3(line3));
    initial forever #10 mclk = ~mclk;
    always @(posedge mclk) begin
        junk <= ~junk;
        if (strobe === 1'b1 && wrCount < 8) begin
            wrSeen[wrCount] <= wrData;
            adSeen[wrCount] <= addr[7:0];
            wrCount <= wrCount + 1;
        end
    end
    task check(input string name, input [7:0] seen, input [7:0] exp);
        begin
            testsRun = testsRun + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("[FAIL] %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    task closeOut;
        begin
            $display("Checks %0d mismatches %0d", testsRun, mismatches);
            if (mismatches == 0 && testsRun > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task waitBusy(input lvl);
        integer n;
        begin
            for (n = 0; n < 400 && busy !== lvl; n = n + 1) @(posedge mclk) #1;
            if (n == 400) begin
                check("busy wait", 8'h00, 8'h01);
                closeOut;
            end
        end
    endtask
    task frame(input sel, input [7:0] cmd, input [7:0] val);
        reg [7:0] rx;
        begin
            @(posedge mclk) #1;
            host.open_frame(sel);
            host.shift(cmd, 1, rx);
            host.shift(val, 1, rx);
            host.close_frame;
        end
    endtask
    task doRead(input [7:0] cmd, input integer w, input [7:0] a, output [7:0] rx);
        begin
            @(posedge mclk) #1;
            host.open_frame(1'b1);
            host.shift(cmd, 1, rx);
            host.shift(8'h00, 1, rx);
            host.shift(8'h01, 1, rx);
            host.shift(a, 1, rx);
            host.shift(8'h00, w, rx);
            host.close_frame;
        end
    endtask
    task tReset;
        begin
            check("standby", {7'h0, standby}, 8'h01);
            check("busy", {7'h0, busy}, 8'h00);
            check("float", {4'h0, e3, e2, e1, e0}, 8'h0f);
            frame(1'b0, 8'h01, 8'h1c);
            check("sr1 deselected", sr1, 8'h00);
        end
    endtask
    task tReadSingle;
        reg [7:0] rx;
        integer m;
        begin
            for (m = 0; m < 2; m = m + 1) begin
                host.cpol = m[0];
                doRead(8'h03, 1, {7'h11, m[0]}, rx);
                check("single read", rx, {7'h11, m[0]} ^ 8'h5a);
            end
        end
    endtask
    task tStatusWp;
        reg [7:0] rx;
        begin
            frame(1'b1, 8'h01, 8'h1c);
            check("sr1 open", sr1 & 8'hfc, 8'h1c);
            @(posedge mclk) #1;
            host.open_frame(1'b1);
            host.shift(8'h05, 1, rx);
            host.shift(8'h00, 1, rx);
            host.close_frame;
            check("sr1 read", rx, 8'h1c);
            host.wpN = 1'b0;
            frame(1'b1, 8'h01, 8'h00);
            check("sr1 locked", sr1 & 8'hfc, 8'h1c);
            host.wpN = 1'b1;
            frame(1'b1, 8'h01, 8'h00);
            check("sr1 reopened", sr1 & 8'hfc, 8'h00);
        end
    endtask
    task tProgram;
        reg [7:0] rx;
        integer k;
        begin
            doRead(8'h02, 1, 8'h40, rx);
            host.open_frame(1'b1);
            host.close_frame;
            @(posedge mclk) #1;
            host.open_frame(1'b1);
            host.shift(8'h02, 1, rx);
            host.shift(8'h00, 1, rx);
            host.shift(8'h00, 1, rx);
            host.shift(8'h40, 1, rx);
            for (k = 0; k < 3; k = k + 1) host.shift({6'h28, k[1:0]}, 1, rx);
            host.close_frame;
            waitBusy(1'b1);
            check("standby busy", {7'h0, standby}, 8'h00);
            waitBusy(1'b0);
            check("strobes", wrCount[7:0], 8'h04);
            for (k = 1; k < 4; k = k + 1) begin
                check("prog data", wrSeen[k], {6'h28, k[1:0] - 2'h1});
                check("prog addr", adSeen[k], {6'h10, k[1:0] - 2'h1});
            end
        end
    endtask
    task tPause;
        reg [7:0] rx;
        begin
            @(posedge mclk) #1;
            host.open_frame(1'b1);
            host.shift(8'h01, 1, rx);
            host.paused_byte(8'hfc);
            host.shift(8'h0c, 1, rx);
            host.close_frame;
            check("sr1 paused", sr1 & 8'hfc, 8'h0c);
            frame(1'b1, 8'h01, 8'h00);
        end
    endtask
    task tReadMulti;
        reg [7:0] rx;
        begin
            frame(1'b1, 8'h31, 8'h02);
            check("sr2 quad", sr2, 8'h02);
            doRead(8'h3b, 2, 8'h55, rx);
            check("dual read", rx, 8'h55 ^ 8'h5a);
            doRead(8'h6b, 4, 8'haa, rx);
            check("quad read", rx, 8'haa ^ 8'h5a);
            frame(1'b1, 8'h31, 8'h00);
        end
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        #1 rstn = 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        tReset;
        tReadSingle;
        tStatusWp;
        tProgram;
        tPause;
        tReadMulti;
        closeOut;
    end
endmodule
